/* include/acc_pkg.sv */
// Shared constants of the converter controller
package acc_pkg;
   // Register byte offsets
   localparam logic [7:0] ACC_OFF_CTRL  = 8'h00; // control_register
   localparam logic [7:0] ACC_OFF_MODE  = 8'h04; // mode_register
   localparam logic [7:0] ACC_OFF_CHEN  = 8'h10; // channel_enable_register
   localparam logic [7:0] ACC_OFF_CHDIS = 8'h14; // channel_disable_register
   localparam logic [7:0] ACC_OFF_CHST  = 8'h18; // enabled channel mask
   localparam logic [7:0] ACC_OFF_LAST  = 8'h20; // last_result_register
   localparam logic [7:0] ACC_OFF_IMSET = 8'h24; // mask set
   localparam logic [7:0] ACC_OFF_IMCLR = 8'h28; // mask clear
   localparam logic [7:0] ACC_OFF_IMASK = 8'h2c; // mask read
   localparam logic [7:0] ACC_OFF_STAT  = 8'h30; // status_register
   localparam logic [7:0] ACC_OFF_OVR   = 8'h3c; // channel overrun flags
   localparam logic [7:0] ACC_OFF_EXT   = 8'h40; // extended_mode_register
   localparam logic [7:0] ACC_OFF_CRES  = 8'h50; // channel_result_register 0
   // Control register fields
   localparam int ACC_CTRL_START = 1;
   // Mode register fields
   localparam int ACC_MODE_HARDWARE_TRIGGER_ENABLE  = 0;  // hardware_trigger_enable
   localparam int ACC_MODE_TRIGGER_SELECT_FIELD = 1;  // trigger_select_field, 3 bits
   localparam int ACC_MODE_LOW_RESOLUTION_BIT = 4;  // low_resolution_bit
   localparam int ACC_MODE_DIV    = 8;  // clock_divider_field, 8 bits
   localparam int ACC_MODE_TRACK  = 24; // tracking_time_field, 4 bits
   localparam int ACC_MODE_XFER   = 28; // transfer time field, 2 bits
   // Extended mode fields
   localparam int ACC_EXT_TAG = 24;
   // Status register fields
   localparam int ACC_ST_DATA_READY_FLAG  = 24;
   localparam int ACC_ST_GENERAL_OVERRUN_FLAG = 25;
   // Last result fields
   localparam int ACC_LAST_CHANNEL_NUMBER_FIELD = 12;
   // Trigger select encodings
   localparam logic [2:0] ACC_TRG_EXT = 3'h3;
   // Reset values
   localparam logic [31:0] ACC_MODE_RST = 32'h0000_0000;
   localparam logic [15:0] ACC_CHEN_RST = 16'h0000;
endpackage

/* rtl/acc_adc_ctrl.sv */
// Converter controller: sequencing, results, flags, triggers, DMA, APB slave
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module acc_adc_ctrl
   import acc_pkg::*;
#(
   parameter int NCH = 16      // Analog channels
) (
   // Clock and reset
   input  wire logic        CLK_I,
   input  wire logic        ARST_N_I,
   // APB slave
   input  wire logic        PSEL_I,
   input  wire logic        PENABLE_I,
   input  wire logic        PWRITE_I,
   input  wire logic [7:0]  PADDR_I,
   input  wire logic [31:0] PWDATA_I,
   output logic      [31:0] PRDATA_O,
   output logic             PREADY_O,
   output logic             PSLVERR_O,
   // Trigger sources
   input  wire logic [2:0]  TIMER_TRIG_I,
   input  wire logic        EXT_TRIG_I,
   // Analog cell
   output logic      [3:0]  CELL_CH_O,
   output logic             CELL_TRACK_O,
   output logic             CELL_CONV_O,
   input  wire logic [9:0]  CELL_DATA_I,
   // DMA and interrupt
   output logic             DMA_REQ_O,
   output logic      [15:0] DMA_DATA_O,
   output logic             IRQ_O
);

   // Sequencer states, one-hot
   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_SYNC  = 4'b0010,
      ST_TRACK = 4'b0100,
      ST_CONV  = 4'b1000
   } acc_state_e;

   // Next enabled channel above from; bit 4 set means none left
   function automatic logic [4:0] next_ch(input logic [15:0] mask, input logic [4:0] from);
      logic [4:0] r;
      r = 5'h10;
      for (int i = NCH - 1; i >= 0; i--) begin
         if (mask[i] && (5'(i) > from || from == 5'h1f)) begin
            r = 5'(i);
         end
      end
      return r;
   endfunction

   // Register file
   logic [31:0] mode_reg;      // Mode settings
   logic        tag_reg;       // Channel tagging
   logic [15:0] chen_reg;      // Enabled channels
   logic [31:0] imask_reg;     // Interrupt mask
   logic [15:0] eoc_reg;       // Per-channel completion
   logic [15:0] ovr_reg;       // Per-channel overrun
   logic        data_ready_flag_reg;      // Data ready
   logic        general_overrun_flag_reg;     // General overrun
   logic [9:0]  cres_reg [NCH]; // Channel results
   logic [9:0]  last_reg;      // Last result
   logic [3:0]  lastch_reg;    // Channel of last result
   // Bus
   logic        rdy_reg;       // Wait state done
   logic [31:0] rdata_reg;     // Captured read data
   logic        err_reg;       // Unmapped answer
   // Sequencer
   acc_state_e  state_reg;
   logic [8:0]  div_reg;       // Prescaler count
   logic        tick;          // Converter clock enable
   logic [4:0]  trk_reg;       // Tracking cycles left
   logic [2:0]  cnv_reg;       // Transfer cycles left
   logic [3:0]  cur_reg;       // Channel in conversion
   logic [3:0]  sel_reg;       // Channel on the mux
   logic        nxt_ok_reg;    // A channel is tracking behind
   logic        trig_reg;      // Pending trigger
   logic        hw_prev_reg;   // Trigger edge memory
   logic        data_ready_flag_prev_reg; // Ready edge memory
   logic [15:0] dma_reg;
   logic        dreq_reg;

   // Decoded strokes
   logic        acc, wr, rd, done, sw_start, hw_sel, hw_edge, rd_last, rd_stat, rd_ovr;
   logic        rd_cres;
   logic [3:0]  rd_ch;
   logic [4:0]  first, after;
   logic [4:0]  trk_load;
   logic [2:0]  cnv_load;
   logic [9:0]  res;

   // Transfer completes on the second access cycle
   assign acc      = PSEL_I & PENABLE_I & rdy_reg;
   assign wr       = acc & PWRITE_I;
   assign rd       = acc & ~PWRITE_I;
   assign rd_last  = rd & (PADDR_I == ACC_OFF_LAST);
   assign rd_stat  = rd & (PADDR_I == ACC_OFF_STAT);
   assign rd_ovr   = rd & (PADDR_I == ACC_OFF_OVR);
   assign rd_cres  = rd & rd_cres_addr(PADDR_I);
   assign rd_ch    = 4'((PADDR_I - ACC_OFF_CRES) >> 2);
   assign sw_start = wr & (PADDR_I == ACC_OFF_CTRL) & PWDATA_I[ACC_CTRL_START];
   assign trk_load = {1'b0, mode_reg[ACC_MODE_TRACK +: 4]} + 5'h01;
   assign cnv_load = {1'b0, mode_reg[ACC_MODE_XFER +: 2]} + 3'h1;
   assign first    = next_ch(chen_reg, 5'h1f);
   assign after    = next_ch(chen_reg, {1'b0, sel_reg});
   assign done     = tick & (state_reg == ST_CONV) & (cnv_reg == 3'h1);

   // Selected hardware source; the enable gates only its edge below
   always_comb begin
      if (mode_reg[ACC_MODE_TRIGGER_SELECT_FIELD +: 3] == ACC_TRG_EXT) begin
         hw_sel = EXT_TRIG_I;
      end else if (mode_reg[ACC_MODE_TRIGGER_SELECT_FIELD +: 3] < ACC_TRG_EXT) begin
         hw_sel = TIMER_TRIG_I[mode_reg[ACC_MODE_TRIGGER_SELECT_FIELD +: 2]];
      end else begin
         hw_sel = 1'b0;                                          // Unused codes
      end
   end
   assign hw_edge = mode_reg[ACC_MODE_HARDWARE_TRIGGER_ENABLE] & hw_sel & ~hw_prev_reg;

   // Result shaped by resolution; low mode keeps top 8 bits in the LSBs
   assign res = mode_reg[ACC_MODE_LOW_RESOLUTION_BIT] ? {2'b00, CELL_DATA_I[9:2]} : CELL_DATA_I;

   // Converter clock enable, one pulse every (div+1)*2 master cycles
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         div_reg <= 9'h000;
      end else if (tick) begin
         div_reg <= 9'h000;
      end else begin
         div_reg <= div_reg + 9'h001;
      end
   end
   assign tick = (div_reg >= {mode_reg[ACC_MODE_DIV +: 8], 1'b1});

   // Trigger capture; a running pass drops new ones
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         hw_prev_reg <= 1'b0;
         trig_reg    <= 1'b0;
      end else begin
         hw_prev_reg <= hw_sel;
         if (state_reg != ST_IDLE) begin
            trig_reg <= 1'b0;
         end else if (sw_start | hw_edge) begin
            trig_reg <= 1'b1;
         end
      end
   end

   // Sequencer: track, transfer, overlap next tracking
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         state_reg  <= ST_IDLE;
         trk_reg    <= 5'h00;
         cnv_reg    <= 3'h0;
         cur_reg    <= 4'h0;
         sel_reg    <= 4'h0;
         nxt_ok_reg <= 1'b0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               // Nothing to convert keeps the pending trigger idle
               if (trig_reg && !first[4]) begin
                  state_reg <= ST_SYNC;
               end
            end
            ST_SYNC: begin
               // Wait for a converter clock edge; sync delay 1 master to 1 converter cycle
               if (tick) begin
                  state_reg <= ST_TRACK;
                  sel_reg   <= first[3:0];
                  trk_reg   <= trk_load;
               end
            end
            ST_TRACK: begin
               if (tick) begin
                  if (trk_reg <= 5'h01) begin
                     state_reg <= ST_CONV;
                     cur_reg   <= sel_reg;
                     cnv_reg   <= cnv_load;
                     // Next channel starts tracking under this conversion
                     nxt_ok_reg <= !after[4];
                     trk_reg    <= after[4] ? 5'h00 : trk_load;
                     sel_reg    <= after[4] ? sel_reg : after[3:0];
                  end else begin
                     trk_reg <= trk_reg - 5'h01;
                  end
               end
            end
            ST_CONV: begin
               if (tick) begin
                  // Next channel's tracking counts down under the transfer
                  trk_reg <= (trk_reg != 5'h00) ? trk_reg - 5'h01 : 5'h00;
                  if (cnv_reg == 3'h1) begin
                     if (!nxt_ok_reg) begin
                        state_reg <= ST_IDLE;
                     end else if (trk_reg <= 5'h01) begin
                        // Tracking already long enough: convert at once
                        cur_reg    <= sel_reg;
                        cnv_reg    <= cnv_load;
                        nxt_ok_reg <= !after[4];
                        trk_reg    <= after[4] ? 5'h00 : trk_load;
                        sel_reg    <= after[4] ? sel_reg : after[3:0];
                     end else begin
                        state_reg <= ST_TRACK;
                     end
                  end else begin
                     cnv_reg <= cnv_reg - 3'h1;
                  end
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // Results land in channel and last registers
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         last_reg   <= 10'h000;
         lastch_reg <= 4'h0;
         for (int i = 0; i < NCH; i++) begin
            cres_reg[i] <= 10'h000;
         end
      end else if (done) begin
         cres_reg[cur_reg] <= res;
         last_reg          <= res;
         lastch_reg        <= cur_reg;
      end
   end

   // Completion and ready flags; a set beats a same-cycle read clear
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         eoc_reg  <= 16'h0000;
         data_ready_flag_reg <= 1'b0;
      end else begin
         for (int i = 0; i < NCH; i++) begin
            if (done && cur_reg == 4'(i)) begin
               eoc_reg[i] <= 1'b1;
            end else if ((rd_cres && rd_ch == 4'(i))
                         || (rd_last && lastch_reg == 4'(i))) begin
               eoc_reg[i] <= 1'b0;
            end
         end
         if (done) begin
            data_ready_flag_reg <= 1'b1;
         end else if (rd_last) begin
            data_ready_flag_reg <= 1'b0;
         end
      end
   end

   // Overrun flags; unread data overwritten is recorded, reads clear
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         ovr_reg   <= 16'h0000;
         general_overrun_flag_reg <= 1'b0;
      end else begin
         for (int i = 0; i < NCH; i++) begin
            if (done && cur_reg == 4'(i) && eoc_reg[i]) begin
               ovr_reg[i] <= 1'b1;
            end else if (rd_ovr) begin
               ovr_reg[i] <= 1'b0;
            end
         end
         if (done && data_ready_flag_reg) begin
            general_overrun_flag_reg <= 1'b1;
         end else if (rd_stat) begin
            general_overrun_flag_reg <= 1'b0;
         end
      end
   end

   // DMA request on each ready rising edge, a channel disabled once selected still converts
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         data_ready_flag_prev_reg <= 1'b0;
         dreq_reg      <= 1'b0;
         dma_reg       <= 16'h0000;
      end else begin
         data_ready_flag_prev_reg <= data_ready_flag_reg;
         dreq_reg      <= data_ready_flag_reg & ~data_ready_flag_prev_reg;
         if (done) begin
            dma_reg <= {tag_reg ? cur_reg : 4'h0, 2'b00, res};
         end
      end
   end

   // Software-written configuration
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         mode_reg  <= ACC_MODE_RST;
         tag_reg   <= 1'b0;
         chen_reg  <= ACC_CHEN_RST;
         imask_reg <= 32'h0000_0000;
      end else if (wr) begin
         case (PADDR_I)
            ACC_OFF_MODE:  mode_reg  <= PWDATA_I;
            ACC_OFF_EXT:   tag_reg   <= PWDATA_I[ACC_EXT_TAG];
            ACC_OFF_CHEN:  chen_reg  <= chen_reg | PWDATA_I[15:0];
            ACC_OFF_CHDIS: chen_reg  <= chen_reg & ~PWDATA_I[15:0];
            ACC_OFF_IMSET: imask_reg <= imask_reg | PWDATA_I;
            ACC_OFF_IMCLR: imask_reg <= imask_reg & ~PWDATA_I;
            default: ; // Other offsets hold no writable state
         endcase
      end
   end

   // Read mux and one wait state; data sampled a cycle before the clear
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         rdy_reg   <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         err_reg   <= 1'b0;
      end else begin
         rdy_reg   <= PSEL_I & PENABLE_I & ~rdy_reg;
         rdata_reg <= 32'h0000_0000;
         err_reg   <= 1'b0;
         if (PSEL_I && PENABLE_I && !rdy_reg) begin
            if (rd_cres_addr(PADDR_I)) begin
               rdata_reg <= {22'h000000, cres_reg[4'((PADDR_I - ACC_OFF_CRES) >> 2)]};
            end else begin
               case (PADDR_I)
                  ACC_OFF_CTRL, ACC_OFF_CHEN, ACC_OFF_CHDIS, ACC_OFF_IMSET, ACC_OFF_IMCLR: begin
                     rdata_reg <= 32'h0000_0000;    // Write-only, read zero
                  end
                  ACC_OFF_MODE:  rdata_reg <= mode_reg;
                  ACC_OFF_EXT:   rdata_reg <= {7'h00, tag_reg, 24'h000000};
                  ACC_OFF_CHST:  rdata_reg <= {16'h0000, chen_reg};
                  ACC_OFF_LAST:  rdata_reg <= {16'h0000, tag_reg ? lastch_reg : 4'h0,
                                              2'b00, last_reg};
                  ACC_OFF_IMASK: rdata_reg <= imask_reg;
                  ACC_OFF_STAT:  rdata_reg <= status_word(eoc_reg, data_ready_flag_reg, general_overrun_flag_reg);
                  ACC_OFF_OVR:   rdata_reg <= {16'h0000, ovr_reg};
                  default:       err_reg   <= 1'b1;      // Unmapped
               endcase
            end
         end
      end
   end

   // Channel result window decode, shared by read capture
   function automatic logic rd_cres_addr(input logic [7:0] a);
      return (a >= ACC_OFF_CRES) && (a < ACC_OFF_CRES + 8'(4 * NCH)) && (a[1:0] == 2'b00);
   endfunction

   // Status word layout; flags passed in so a continuous use sees each change
   function automatic logic [31:0] status_word(input logic [15:0] e, input logic d, g);
      logic [31:0] s;
      s = {16'h0000, e};
      s[ACC_ST_DATA_READY_FLAG]  = d;
      s[ACC_ST_GENERAL_OVERRUN_FLAG] = g;
      return s;
   endfunction

   // Outputs
   assign PREADY_O     = rdy_reg;
   assign PRDATA_O     = rdata_reg;
   assign PSLVERR_O    = err_reg & rdy_reg;
   assign CELL_CH_O    = sel_reg;
   assign CELL_TRACK_O = (state_reg == ST_TRACK) | ((state_reg == ST_CONV) & nxt_ok_reg);
   assign CELL_CONV_O  = (state_reg == ST_CONV);
   assign DMA_REQ_O    = dreq_reg;
   assign DMA_DATA_O   = dma_reg;
   assign IRQ_O        = |(status_word(eoc_reg, data_ready_flag_reg, general_overrun_flag_reg) & imask_reg);

endmodule

/* verification/acc_adc_ctrl_monitor.sv */
// Port-level assertions of the converter controller
`timescale 1ns/1ps
module acc_adc_ctrl_monitor (
   // Clock and reset
   input wire logic        CLK_I,
   input wire logic        ARST_N_I,
   // APB handshake
   input wire logic        PSEL_I,
   input wire logic        PENABLE_I,
   input wire logic [31:0] PRDATA_O,
   input wire logic        PREADY_O,
   input wire logic        PSLVERR_O,
   // Cell phases and DMA
   input wire logic        CELL_TRACK_O,
   input wire logic        CELL_CONV_O,
   input wire logic        DMA_REQ_O,
   input wire logic [15:0] DMA_DATA_O
);
   // One clock domain, so one clocking and one disable
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!ARST_N_I);
   // Exactly one wait state, then the answer
   ready_wait_a: assert property (PSEL_I && $rose(PENABLE_I) |-> !PREADY_O ##1 PREADY_O)
      else $error("answer not in second access cycle");
   // Answer stands a single cycle
   ready_single_a: assert property (PREADY_O |=> !PREADY_O)
      else $error("ready held too long");
   // Answer only inside an access phase
   ready_access_a: assert property (PREADY_O |-> PSEL_I && PENABLE_I)
      else $error("ready outside access phase");
   // Error only together with the answer
   err_with_ready_a: assert property (PSLVERR_O |-> PREADY_O)
      else $error("error without ready");
   // Read bus quiet between answers
   rdata_idle_a: assert property (!PREADY_O |-> PRDATA_O == 32'h0000_0000)
      else $error("read data outside answer");
   // Transfer request is a one-cycle pulse
   dma_pulse_a: assert property (DMA_REQ_O |=> !DMA_REQ_O)
      else $error("dma request longer than a cycle");
   // Half-word keeps gap bits clear
   dma_layout_a: assert property (DMA_REQ_O |-> DMA_DATA_O[11:10] == 2'b00)
      else $error("dma word layout broken");
   // Transfer phase always follows tracking
   conv_after_track_a: assert property ($rose(CELL_CONV_O) |-> $past(CELL_TRACK_O))
      else $error("transfer without tracking");
   // Tracking ends into a transfer phase
   track_into_conv_a: assert property ($fell(CELL_TRACK_O) |-> CELL_CONV_O)
      else $error("tracking ended without transfer");
endmodule

bind acc_adc_ctrl acc_adc_ctrl_monitor i_acc_adc_ctrl_monitor (
   .CLK_I       (CLK_I),
   .ARST_N_I    (ARST_N_I),
   .PSEL_I      (PSEL_I),
   .PENABLE_I   (PENABLE_I),
   .PRDATA_O    (PRDATA_O),
   .PREADY_O    (PREADY_O),
   .PSLVERR_O   (PSLVERR_O),
   .CELL_TRACK_O(CELL_TRACK_O),
   .CELL_CONV_O (CELL_CONV_O),
   .DMA_REQ_O   (DMA_REQ_O),
   .DMA_DATA_O  (DMA_DATA_O)
);

/* verification/acc_cell_model.sv */
// Behavioural analog cell answering the controller
`timescale 1ns/1ps
module acc_cell_model (
   // Clock
   input  wire logic       clk_i,
   // Mux and phase
   input  wire logic [3:0] ch_i,
   input  wire logic       trk_i,
   input  wire logic       conv_i,
   // Result
   output logic      [9:0] data_o
);
   logic [9:0] idle_reg = 10'h155; // Filler outside transfer
   logic [3:0] last_ch  = 4'h0;    // Mux one cycle back
   logic [3:0] held_ch  = 4'h0;    // Channel caught by the sample
   logic       last_trk = 1'b0;    // Tracking one cycle back
   logic       last_cnv = 1'b0;    // Transfer one cycle back
   // Filler flips each cycle so a stray sample never looks valid; the mux
   // moves on during a transfer, so the converted channel is the one on it
   // just before that transfer began
   always @(posedge clk_i) begin
      idle_reg <= ~idle_reg;
      last_ch  <= ch_i;
      last_trk <= trk_i;
      last_cnv <= conv_i;
      if (conv_i && (!last_cnv || (last_trk && !trk_i) || ch_i != last_ch)) begin
         held_ch <= last_ch;
      end
   end
   // Result names its channel, so a wrong mux shows up
   assign data_o = conv_i ? {held_ch, 6'h2a} : idle_reg;
endmodule

/* verification/acc_adc_ctrl_tb.sv */
// Self-checking bench of the converter controller
`timescale 1ns/1ps
module acc_adc_ctrl_tb
   import acc_pkg::*;
;
   typedef struct packed {
      logic [3:0] ch;     // Channel converted
      logic       low_resolution_bit; // Eight-bit mode
      logic       tag;    // Channel tagging
      logic [9:0] res;    // Expected result
   } acc_row_s;
   acc_row_s    rows [4] = '{'{4'h0, 1'b0, 1'b0, 10'h02a}, '{4'h5, 1'b1, 1'b1, 10'h05a},
                             '{4'hf, 1'b0, 1'b1, 10'h3ea}, '{4'h9, 1'b1, 1'b0, 10'h09a}};
   logic        clk      = 1'b0;   // Master clock
   logic        arst_n   = 1'b0;   // Reset, low active
   logic        psel     = 1'b0;   // APB select
   logic        penable  = 1'b0;   // APB enable
   logic        pwrite   = 1'b0;   // APB direction
   logic [7:0]  paddr    = 8'h00;  // APB address
   logic [31:0] pwdata   = 32'h0;  // APB write data
   logic [2:0]  tmr_trig = 3'h0;   // Timer sources
   logic        ext_trig = 1'b0;   // External source
   logic [31:0] prdata, rd;        // Read bus and last read
   logic        pready, pslverr, rd_err, cell_track, cell_conv, dma_req, irq;
   logic [3:0]  cell_ch;           // Mux select
   logic [9:0]  cell_data;         // Cell result
   logic [15:0] dma_data, dma_w;   // DMA word and expected word
   logic [15:0] dma_q [$];         // Captured DMA words
   int          error_cnt = 0;
   int          check_count = 0;
   int          cyc = 0;

   always #12.5 clk = ~clk;

   acc_adc_ctrl i_acc_adc_ctrl (.CLK_I(clk), .ARST_N_I(arst_n), .PSEL_I(psel),
      .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
      .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .TIMER_TRIG_I(tmr_trig),
      .EXT_TRIG_I(ext_trig), .CELL_CH_O(cell_ch), .CELL_TRACK_O(cell_track),
      .CELL_CONV_O(cell_conv), .CELL_DATA_I(cell_data), .DMA_REQ_O(dma_req),
      .DMA_DATA_O(dma_data), .IRQ_O(irq));
   acc_cell_model i_acc_cell_model (.clk_i(clk), .ch_i(cell_ch), .trk_i(cell_track),
      .conv_i(cell_conv), .data_o(cell_data));

   // Request is one cycle, so sampling once per edge is exact
   always @(posedge clk) begin
      if (dma_req === 1'b1) begin
         dma_q.push_back(dma_data);
      end
   end

   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: %s got %h want %h", $time, what, seen, exp);
      end
   endtask

   // One APB transfer; request held until ready is sampled
   // No cycle count assumed; only the hang guard ends a stuck wait
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Wait for tracking to start, then for the cell to fall quiet
   task automatic wait_pass();
      int   n = 0;
      logic seen;
      while (cell_track !== 1'b1 && n < 400) begin
         @(posedge clk);
         n++;
      end
      seen = (n < 400);
      while ((cell_track | cell_conv) !== 1'b0 && n < 2000) begin
         @(posedge clk);
         n++;
      end
      chk({31'h0, seen && n < 2000}, 32'h1, "pass seen");
      repeat (4) @(posedge clk);
   endtask

   // Hang guard well above the expected run length
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         $display("mismatch at %0t: timeout", $time);
         complete_run();
      end
   end

   initial begin
      repeat (20) @(posedge clk);
      arst_n <= 1'b1;
      apb(1'b0, ACC_OFF_MODE, 32'h0);
      chk(rd, ACC_MODE_RST, "mode reset");
      apb(1'b0, ACC_OFF_CHST, 32'h0);
      chk(rd, {16'h0, ACC_CHEN_RST}, "enable reset");
      apb(1'b0, 8'h1c, 32'h0);
      chk({31'h0, rd_err}, 32'h1, "reserved refused");
      $display("reset test done");
      // Single-channel passes in each resolution and tag mode
      foreach (rows[i]) begin
         dma_w = {rows[i].tag ? rows[i].ch : 4'h0, 2'b00, rows[i].res};
         apb(1'b1, ACC_OFF_CHDIS, 32'hffff);
         apb(1'b1, ACC_OFF_CHEN, 32'h1 << rows[i].ch);
         apb(1'b1, ACC_OFF_MODE, {27'h0, rows[i].low_resolution_bit, 4'h0});
         apb(1'b1, ACC_OFF_EXT, {7'h0, rows[i].tag, 24'h0});
         apb(1'b1, ACC_OFF_CTRL, 32'h2);
         wait_pass();
         apb(1'b0, ACC_OFF_CRES + {rows[i].ch, 2'b00}, 32'h0);
         chk(rd, {22'h0, rows[i].res}, "channel result");
         apb(1'b0, ACC_OFF_STAT, 32'h0);
         chk(rd, 32'h0100_0000, "flags after channel read");
         apb(1'b0, ACC_OFF_LAST, 32'h0);
         chk(rd, {16'h0, dma_w}, "last result");
         apb(1'b0, ACC_OFF_STAT, 32'h0);
         chk(rd, 32'h0, "flags after last read");
         chk(dma_q.size(), 32'h1, "dma count");
         chk({16'h0, dma_q.pop_front()}, {16'h0, dma_w}, "dma word");
         $display("row %0d done", i);
      end
      // Two channels in one pass, then a second pass left unread
      apb(1'b1, ACC_OFF_CHDIS, 32'hffff);
      apb(1'b1, ACC_OFF_CHEN, 32'h008c);
      apb(1'b1, ACC_OFF_CHDIS, 32'h0004);
      apb(1'b0, ACC_OFF_CHST, 32'h0);
      chk(rd, 32'h0000_0088, "enable mask");
      apb(1'b1, ACC_OFF_EXT, 32'h0100_0000);
      apb(1'b1, ACC_OFF_CTRL, 32'h2);
      wait_pass();
      chk(dma_q.size(), 32'h1, "one request per rise");
      dma_w = dma_q.pop_front();
      chk({28'h0, dma_w[15:12]}, 32'h3, "first channel");
      apb(1'b0, ACC_OFF_STAT, 32'h0);
      chk(rd, 32'h0300_0088, "flags after pass");
      apb(1'b0, ACC_OFF_LAST, 32'h0);
      chk(rd, 32'h0000_707a, "last channel");
      apb(1'b1, ACC_OFF_CTRL, 32'h2);
      wait_pass();
      apb(1'b0, ACC_OFF_OVR, 32'h0);
      chk(rd, 32'h0000_0008, "channel overrun");
      apb(1'b0, ACC_OFF_OVR, 32'h0);
      chk(rd, 32'h0, "overrun cleared");
      apb(1'b0, ACC_OFF_STAT, 32'h0);
      chk(rd, 32'h0300_0088, "general overrun");
      apb(1'b0, ACC_OFF_STAT, 32'h0);
      chk(rd, 32'h0100_0088, "general overrun cleared");
      $display("overrun test done");
      // Hardware source: wrong source ignored, then start mid-pass ignored
      dma_q.delete();
      apb(1'b1, ACC_OFF_CHDIS, 32'hffff);
      apb(1'b1, ACC_OFF_CHEN, 32'h1);
      apb(1'b0, ACC_OFF_LAST, 32'h0);
      apb(1'b1, ACC_OFF_MODE, 32'h0f00_0007);
      tmr_trig <= 3'h7;
      repeat (40) @(posedge clk);
      apb(1'b0, ACC_OFF_STAT, 32'h0);
      chk(rd, 32'h0000_0008, "unselected source");
      ext_trig <= 1'b1;
      repeat (8) @(posedge clk);
      apb(1'b1, ACC_OFF_CTRL, 32'h2);
      wait_pass();
      repeat (100) @(posedge clk);
      apb(1'b0, ACC_OFF_STAT, 32'h0);
      chk(rd, 32'h0100_0009, "single pass");
      @(negedge clk);
      chk({31'h0, irq}, 32'h0, "masked");
      apb(1'b1, ACC_OFF_IMSET, 32'h0100_0000);
      @(negedge clk);
      chk({31'h0, irq}, 32'h1, "unmasked");
      apb(1'b1, ACC_OFF_IMCLR, 32'h0100_0000);
      @(negedge clk);
      chk({31'h0, irq}, 32'h0, "masked again");
      // Timer source one: let the edge memory settle low before the rise
      tmr_trig <= 3'h0;
      apb(1'b1, ACC_OFF_MODE, 32'h0000_0003);
      repeat (2) @(posedge clk);
      tmr_trig <= 3'h2;
      wait_pass();
      apb(1'b0, ACC_OFF_STAT, 32'h0);
      chk(rd, 32'h0300_0009, "timer source");
      apb(1'b0, ACC_OFF_CRES + 8'h0c, 32'h0);
      chk(rd, 32'h0000_003a, "overlapped channel");
      $display("trigger test done");
      complete_run();
   end
endmodule
